// ===== pkg/pss_pkg.sv
// Constants, state codes and carrier types of the power supply status logic
package pss_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_KHZ = 40000;
  localparam int PG_DELAY_MS = 100;
  localparam int PG_LOW_MS = 100;
  localparam int PG_DROP_MS = 5;
  localparam int VIN_DROP_MS = 3;
  localparam int ALERT_HOLD_MS = 100;
  localparam int HOLDUP_MS = 10;
  localparam int PG_DELAY_CYC = PG_DELAY_MS * CLK_KHZ;
  localparam int PG_LOW_CYC = PG_LOW_MS * CLK_KHZ;
  localparam int PG_DROP_CYC = PG_DROP_MS * CLK_KHZ;
  localparam int VIN_DROP_CYC = VIN_DROP_MS * CLK_KHZ;
  localparam int ALERT_HOLD_CYC = ALERT_HOLD_MS * CLK_KHZ;
  localparam int HOLDUP_CYC = HOLDUP_MS * CLK_KHZ;
  localparam int CNT_W = 25;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam logic [7:0] REG_TELE_BASE = 8'h10;
  localparam logic [3:0] TELE_COUNT = 4'hA;
  localparam int TELE_DEPTH = 16;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // CTRL fields
  localparam int CTRL_COLD_EN = 0;
  localparam int CTRL_SPARE = 1;
  localparam int CTRL_GROUP_LO = 2;
  localparam int CTRL_OPT_ALERT = 4;

  // STATUS fields
  localparam int ST_PGOOD = 0;
  localparam int ST_ALERT = 1;
  localparam int ST_VIN_GOOD = 2;
  localparam int ST_SLEEP = 3;
  localparam int ST_MAIN_EN = 4;
  localparam int ST_ADDR_LO = 5;
  localparam int ST_PG_LO = 7;
  localparam int ST_AC_LOST = 9;
  localparam int ST_PGOOD_PIN = 10;
  localparam int ST_ALERT_PIN = 11;
  localparam int ST_VIN_PIN = 12;
  localparam int ST_PRES_PIN = 13;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    PSS_PG_OFF = 2'b00,
    PSS_PG_WAIT = 2'b01,
    PSS_PG_ON = 2'b10
  } pss_pg_e;

  typedef enum logic [1:0] {
    PSS_GRP_1P1 = 2'b00,
    PSS_GRP_2P1 = 2'b01,
    PSS_GRP_3P1 = 2'b10,
    PSS_GRP_2P2 = 2'b11
  } pss_group_e;

  // Comparator and monitor flags from the power stage
  typedef struct packed {
    logic outputs_in_reg;
    logic current_limit;
    logic input_present;
    logic input_in_range;
    logic over_temp_warn;
    logic over_current;
    logic over_voltage;
    logic under_voltage;
    logic fan_fail;
    logic end_of_life;
    logic env_exceed;
  } pss_flags_s;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pss_reg_req_s;

endpackage

// ===== hw/pss_tele_mem.sv
// Telemetry word store with a registered read port and a bypass word
`timescale 1ns/100ps
module pss_tele_mem (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic rd_en,
  input wire logic rd_mem,
  input wire logic [3:0] rd_idx,
  input wire logic [15:0] byp_data,
  output logic [15:0] rd_data_q
);

  logic [15:0] mem_q [pss_pkg::TELE_DEPTH];

  // ****************************************
  // Storage
  // ****************************************
  // No reset on the array, it is filled by the sampler
  always_ff @(posedge mclk) begin
    if (ce && wr_en) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  // Read register also carries register-file words so the bus sees one flop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data_q <= 16'h0000;
    end else if (ce && rd_en) begin
      rd_data_q <= rd_mem ? mem_q[rd_idx] : byp_data;
    end
  end

endmodule

// ===== hw/pss_status.sv
// Power supply status signalling: power good, alert, input good, presence, cold spare
`timescale 1ns/100ps
// How it works
// - Power good high only when outputs regulate
// - Drop power good on underregulation or holdup loss
// - Current limit restarts power good timer
// - Alert low on any critical or warning
// - Temperature, current, voltage, fan raise alert
// - Optional end-of-life and environment alert sources
// - Alert and red indicator switch together
// - Spare sleeps when cold bus high
// - Cold bus low wakes sleeping spares
// - Grouping field covers four spare layouts
// - Cold spare controlled through command registers
// - Presence line held low always
// - Input good only with input in range
// - Input good low within 3 ms
// - No input keeps input good low
// - Address select pins give address bits
// - Telemetry words readable over register port
// - Power good 100 to 500 ms after regulation
// - Power good drops within 5 ms
// - Power good low at least 100 ms
// - Alert held at least 100 ms
module pss_status #(
  parameter logic [24:0] PG_DELAY_CYC = 25'(pss_pkg::PG_DELAY_CYC),
  parameter logic [24:0] PG_LOW_CYC = 25'(pss_pkg::PG_LOW_CYC),
  parameter logic [24:0] ALERT_HOLD_CYC = 25'(pss_pkg::ALERT_HOLD_CYC),
  parameter logic [24:0] HOLDUP_CYC = 25'(pss_pkg::HOLDUP_CYC)
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire pss_pkg::pss_flags_s flags,
  input wire logic on_request_n,
  input wire logic cold_bus_in,
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic tele_wr,
  input wire logic [3:0] tele_idx,
  input wire logic [15:0] tele_data,
  input wire pss_pkg::pss_reg_req_s reg_req,
  output logic [15:0] reg_rdata,
  input wire logic pgood_i,
  output logic pgood_o,
  output logic pgood_oe,
  input wire logic alert_n_i,
  output logic alert_n_o,
  output logic alert_n_oe,
  input wire logic vin_good_i,
  output logic vin_good_o,
  output logic vin_good_oe,
  input wire logic unit_installed_n_i,
  output logic unit_installed_n_o,
  output logic unit_installed_n_oe,
  output logic main_enable,
  output logic sleep_active,
  output logic led_red,
  output logic [1:0] smbus_addr_lo
);

  // ****************************************
  // State
  // ****************************************
  // One packed state word; the next-state logic fills a copy each cycle
  typedef struct packed {
    pss_pkg::pss_pg_e pg_st;
    logic [24:0] pg_cnt;
    logic [24:0] low_cnt;
    logic [24:0] ac_cnt;
    logic [24:0] alert_cnt;
    logic pgood;
    logic alert;
    logic vin_good;
    logic sleep;
    logic main_en;
    logic [1:0] addr_lo;
    logic cold_en;
    logic spare;
    pss_pkg::pss_group_e group;
    logic opt_alert;
    logic pg_pull;
    logic vin_pull;
    logic pres_pull;
  } pss_state_s;

  // State pair plus helper terms decoded from state and live inputs
  pss_state_s st_q;
  pss_state_s st_d;
  logic ac_lost;
  logic run_ok;
  logic src_any;
  logic rd_mem;
  logic [15:0] byp_word;
  logic [7:0] tele_off;

  // ****************************************
  // Derived conditions
  // ****************************************
  // Holdup window expired while input is missing
  assign ac_lost = (st_q.ac_cnt >= HOLDUP_CYC);
  // Unit is asked to run and is not parked as spare
  assign run_ok = !on_request_n && !st_q.sleep && flags.outputs_in_reg && !ac_lost;
  // optional sources behind a control bit
  assign src_any = flags.over_temp_warn || flags.over_current || flags.over_voltage ||
                   flags.under_voltage || flags.fan_fail ||
                   (st_q.opt_alert && (flags.end_of_life || flags.env_exceed));
  // Offset into the telemetry window, wraps below the base and fails the range test
  assign tele_off = reg_req.addr - pss_pkg::REG_TELE_BASE;
  assign rd_mem = (reg_req.addr >= pss_pkg::REG_TELE_BASE) &&
                  (tele_off < {4'h0, pss_pkg::TELE_COUNT});

  // Register words other than telemetry, unmapped reads return zero
  always_comb begin
    byp_word = 16'h0000;
    if (reg_req.addr == pss_pkg::REG_CTRL) begin
      byp_word[pss_pkg::CTRL_COLD_EN] = st_q.cold_en;
      byp_word[pss_pkg::CTRL_SPARE] = st_q.spare;
      byp_word[pss_pkg::CTRL_GROUP_LO +: 2] = st_q.group;
      byp_word[pss_pkg::CTRL_OPT_ALERT] = st_q.opt_alert;
    end else if (reg_req.addr == pss_pkg::REG_STATUS) begin
      // Pin read-backs show the resolved line levels, not our own enables
      byp_word[pss_pkg::ST_PGOOD] = st_q.pgood;
      byp_word[pss_pkg::ST_ALERT] = st_q.alert;
      byp_word[pss_pkg::ST_VIN_GOOD] = st_q.vin_good;
      byp_word[pss_pkg::ST_SLEEP] = st_q.sleep;
      byp_word[pss_pkg::ST_MAIN_EN] = st_q.main_en;
      byp_word[pss_pkg::ST_ADDR_LO +: 2] = st_q.addr_lo;
      byp_word[pss_pkg::ST_PG_LO +: 2] = st_q.pg_st;
      byp_word[pss_pkg::ST_AC_LOST] = ac_lost;
      byp_word[pss_pkg::ST_PGOOD_PIN] = pgood_i;
      byp_word[pss_pkg::ST_ALERT_PIN] = alert_n_i;
      byp_word[pss_pkg::ST_VIN_PIN] = vin_good_i;
      byp_word[pss_pkg::ST_PRES_PIN] = unit_installed_n_i;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    // Everything holds unless a branch below moves it
    st_d = st_q;
    // Straps are static levels, so no synchroniser is spent on them
    // address select pins sampled every cycle
    st_d.addr_lo = {addr_select_bit1, addr_select_bit0};

    // Only the control offset is writable, writes elsewhere are dropped
    // cold spare setup through the control register
    if (reg_req.wr && reg_req.addr == pss_pkg::REG_CTRL) begin
      st_d.cold_en = reg_req.wdata[pss_pkg::CTRL_COLD_EN];
      st_d.spare = reg_req.wdata[pss_pkg::CTRL_SPARE];
      st_d.group = pss_pkg::pss_group_e'(reg_req.wdata[pss_pkg::CTRL_GROUP_LO +: 2]);
      st_d.opt_alert = reg_req.wdata[pss_pkg::CTRL_OPT_ALERT];
    end

    // spare parks while shared bus is high
    // low bus returns it to redundant duty
    st_d.sleep = st_q.cold_en && st_q.spare && cold_bus_in;
    st_d.main_en = !on_request_n && !st_d.sleep;

    // Holdup counter, saturating so a long outage stays lost
    // Dips shorter than the holdup window leave power good alone
    if (flags.input_present) begin
      st_d.ac_cnt = 25'h0000000;
    end else if (!ac_lost) begin
      st_d.ac_cnt = st_q.ac_cnt + 25'h0000001;
    end

    // input good only with input present and in range
    // cleared the cycle after input vanishes, well inside 3 ms
    st_d.vin_good = flags.input_present && flags.input_in_range;
    // Drain enable in a flop of its own so the pin has no gate after the register
    st_d.vin_pull = !st_d.vin_good;

    // Power good sequencing
    // Every drop clears the low timer, so off time counts from the fall
    unique case (st_q.pg_st)
      pss_pkg::PSS_PG_OFF: begin
        // minimum low time before any new rise
        if (st_q.low_cnt < PG_LOW_CYC) begin
          st_d.low_cnt = st_q.low_cnt + 25'h0000001;
        end else if (run_ok) begin
          st_d.pg_st = pss_pkg::PSS_PG_WAIT;
          st_d.pg_cnt = 25'h0000000;
        end
      end
      pss_pkg::PSS_PG_WAIT: begin
        // Losing the start condition abandons the delay
        if (!run_ok) begin
          st_d.pg_st = pss_pkg::PSS_PG_OFF;
          st_d.low_cnt = 25'h0000000;
        end else if (flags.current_limit) begin
          // delay restarts only once current limit ends
          st_d.pg_cnt = 25'h0000000;
        end else if (st_q.pg_cnt >= PG_DELAY_CYC - 25'h0000001) begin
          // rises at the delay count, between 100 and 500 ms
          st_d.pg_st = pss_pkg::PSS_PG_ON;
        end else begin
          st_d.pg_cnt = st_q.pg_cnt + 25'h0000001;
        end
      end
      pss_pkg::PSS_PG_ON: begin
        // regulation loss or holdup loss drops power good
        // on request release drops it next cycle
        if (!run_ok) begin
          st_d.pg_st = pss_pkg::PSS_PG_OFF;
          st_d.low_cnt = 25'h0000000;
        end
      end
      default: begin
        st_d.pg_st = pss_pkg::PSS_PG_OFF;
        st_d.low_cnt = 25'h0000000;
      end
    endcase
    // high only while sequencer stands in the on state
    st_d.pgood = (st_d.pg_st == pss_pkg::PSS_PG_ON);
    // Pull the line low in every state but on
    st_d.pg_pull = !st_d.pgood;
    st_d.pres_pull = 1'b1;

    // Hold counts from the last source cycle, so a chattering source keeps it low
    // any source asserts the alert, restarting the hold
    // held for the full latch time
    // released only after hold and with sources gone
    if (src_any) begin
      st_d.alert = 1'b1;
      st_d.alert_cnt = 25'h0000000;
    end else if (st_q.alert) begin
      if (st_q.alert_cnt >= ALERT_HOLD_CYC - 25'h0000001) begin
        st_d.alert = 1'b0;
      end else begin
        st_d.alert_cnt = st_q.alert_cnt + 25'h0000001;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Reset leaves power good low with the low timer at zero, so a full off time comes first
  // Clock enable low freezes every field, timers included
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= '{pg_st: pss_pkg::PSS_PG_OFF, pg_cnt: 25'h0000000, low_cnt: 25'h0000000,
                ac_cnt: 25'h0000000, alert_cnt: 25'h0000000, pgood: 1'b0, alert: 1'b0,
                vin_good: 1'b0, sleep: 1'b0, main_en: 1'b0, addr_lo: 2'h3,
                cold_en: pss_pkg::CTRL_RESET[pss_pkg::CTRL_COLD_EN],
                spare: pss_pkg::CTRL_RESET[pss_pkg::CTRL_SPARE],
                group: pss_pkg::PSS_GRP_1P1,
                opt_alert: pss_pkg::CTRL_RESET[pss_pkg::CTRL_OPT_ALERT],
                pg_pull: 1'b1, vin_pull: 1'b1, pres_pull: 1'b1};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // Bypass word and telemetry share one read flop, so every read answers alike
  // Idle cycles keep the last word, the read flop only loads on a strobe
  // telemetry store, read data registered
  pss_tele_mem u_mem (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .wr_en(tele_wr),
    .wr_idx(tele_idx),
    .wr_data(tele_data),
    .rd_en(reg_req.rd),
    .rd_mem(rd_mem),
    .rd_idx(tele_off[3:0]),
    .byp_data(byp_word),
    .rd_data_q(reg_rdata)
  );

  // ****************************************
  // Pin drive
  // ****************************************
  // Open-drain pins only ever pull low; the level comes from the enable
  assign pgood_o = 1'b0;
  assign alert_n_o = 1'b0;
  assign vin_good_o = 1'b0;
  assign unit_installed_n_o = 1'b0;
  // Enables high mean the pin is pulled low
  assign pgood_oe = st_q.pg_pull;
  // red indicator and alert share one flop
  assign alert_n_oe = st_q.alert;
  assign led_red = st_q.alert;
  assign vin_good_oe = st_q.vin_pull;
  assign unit_installed_n_oe = st_q.pres_pull;
  // Plain status outputs, each straight from its state flop
  assign main_enable = st_q.main_en;
  assign sleep_active = st_q.sleep;
  assign smbus_addr_lo = st_q.addr_lo;

endmodule

// ===== testbench/pss_status_sva.sv
// Port assertions for the power supply status logic
`timescale 1ns/100ps
module pss_status_sva #(
  parameter logic [24:0] PG_DELAY_CYC = 25'h14,
  parameter logic [24:0] PG_LOW_CYC = 25'h0A,
  parameter logic [24:0] ALERT_HOLD_CYC = 25'h0F
) (
  input wire logic mclk,
  input wire logic rst,
  input wire pss_pkg::pss_flags_s flags,
  input wire logic on_request_n,
  input wire logic cold_bus_in,
  input wire logic pgood_o,
  input wire logic pgood_oe,
  input wire logic alert_n_o,
  input wire logic alert_n_oe,
  input wire logic vin_good_o,
  input wire logic vin_good_oe,
  input wire logic unit_installed_n_o,
  input wire logic unit_installed_n_oe,
  input wire logic main_enable,
  input wire logic sleep_active,
  input wire logic led_red
);
  logic src;
  logic run;
  logic [24:0] run_q;
  logic [24:0] low_q;
  logic [24:0] hi_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  assign src = flags.over_temp_warn | flags.over_current | flags.over_voltage
    | flags.under_voltage | flags.fan_fail;
  // Ignores the holdup loss, so the run length is an upper bound of the timer
  assign run = flags.outputs_in_reg & !flags.current_limit & !on_request_n & !sleep_active;
  // Run lengths of the start condition and of the asserted outputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_q <= 25'h0;
      low_q <= 25'h0;
      hi_q <= 25'h0;
    end else begin
      run_q <= run ? run_q + 25'h1 : 25'h0;
      low_q <= pgood_oe ? low_q + 25'h1 : 25'h0;
      hi_q <= alert_n_oe ? hi_q + 25'h1 : 25'h0;
    end
  end
  a_pg_in_reg: assert property (!pgood_oe |-> $past(flags.outputs_in_reg))
    else $error("power good without regulation");
  a_pg_reg_drop: assert property (!flags.outputs_in_reg |=> pgood_oe)
    else $error("power good kept after regulation loss");
  a_pg_delay_run: assert property ($fell(pgood_oe) |-> run_q >= PG_DELAY_CYC)
    else $error("power good rose too early");
  a_pg_req_drop: assert property (on_request_n |=> pgood_oe)
    else $error("power good kept after off request");
  a_pg_low_time: assert property ($fell(pgood_oe) |-> low_q >= PG_LOW_CYC)
    else $error("power good low time too short");
  a_alert_src: assert property (src |=> alert_n_oe && !alert_n_o)
    else $error("alert missing after source");
  a_alert_led: assert property (led_red == alert_n_oe)
    else $error("red indicator and alert differ");
  a_alert_hold: assert property ($fell(alert_n_oe) |-> hi_q >= ALERT_HOLD_CYC - 25'h1)
    else $error("alert released too soon");
  a_alert_free: assert property ($fell(alert_n_oe) |-> !$past(src))
    else $error("alert released with source active");
  a_pres_low: assert property (unit_installed_n_oe && !unit_installed_n_o && !pgood_o)
    else $error("presence or drain level wrong");
  a_vin_range: assert property (!vin_good_oe |-> $past(flags.input_present
    && flags.input_in_range) && !vin_good_o)
    else $error("input good without input");
  a_vin_loss: assert property (!flags.input_present |=> vin_good_oe)
    else $error("input good kept without input");
  a_spare_off: assert property (sleep_active |-> !main_enable)
    else $error("main output on while asleep");
  a_spare_wake: assert property (!cold_bus_in |=> !sleep_active)
    else $error("spare stays asleep");
endmodule
bind pss_status pss_status_sva #(.PG_DELAY_CYC(PG_DELAY_CYC), .PG_LOW_CYC(PG_LOW_CYC),
  .ALERT_HOLD_CYC(ALERT_HOLD_CYC)) i_sva (.mclk(mclk), .rst(rst), .flags(flags),
  .on_request_n(on_request_n), .cold_bus_in(cold_bus_in), .pgood_o(pgood_o),
  .pgood_oe(pgood_oe), .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe),
  .vin_good_o(vin_good_o), .vin_good_oe(vin_good_oe), .unit_installed_n_o(unit_installed_n_o),
  .unit_installed_n_oe(unit_installed_n_oe), .main_enable(main_enable),
  .sleep_active(sleep_active), .led_red(led_red));

// ===== testbench/pss_board_model.sv
// Board side model: pull-ups on the drain lines and the shared spare bus
`timescale 1ns/100ps
module pss_board_model (
  input wire logic pgood_o,
  input wire logic pgood_oe,
  input wire logic alert_n_o,
  input wire logic alert_n_oe,
  input wire logic vin_good_o,
  input wire logic vin_good_oe,
  input wire logic inst_o,
  input wire logic inst_oe,
  input wire logic cold_cmd,
  output logic pgood_pin,
  output logic alert_pin,
  output logic vin_pin,
  output logic inst_pin,
  output logic cold_bus
);
  // released lines go to their pull-up level
  assign pgood_pin = pgood_oe ? pgood_o : 1'b1;
  assign alert_pin = alert_n_oe ? alert_n_o : 1'b1;
  assign vin_pin = vin_good_oe ? vin_good_o : 1'b1;
  assign inst_pin = inst_oe ? inst_o : 1'b1;
  // one shared net, no other unit fitted here
  assign cold_bus = cold_cmd;
endmodule

// ===== testbench/pss_status_tb.sv
// Self-checking bench for the power supply status logic
`timescale 1ns/100ps
module pss_status_tb;
  localparam int PL = 10;
  localparam int PD = 20;
  localparam int AH = 15;
  logic mclk, rst, ce, on_n, cold_cmd, cold_bus, a0, a1, t_wr;
  logic [3:0] t_idx;
  logic [15:0] t_data, rdata, rd_q;
  logic [1:0] addr_lo;
  pss_pkg::pss_flags_s flg;
  pss_pkg::pss_reg_req_s req;
  logic pg_i, pg_o, pg_oe, al_i, al_o, al_oe, vi_i, vi_o, vi_oe, in_i, in_o, in_oe;
  logic main_en, sleep, led;
  int mismatches, n_checks, n;
  pss_status #(.PG_DELAY_CYC(25'h14), .PG_LOW_CYC(25'h0A), .ALERT_HOLD_CYC(25'h0F),
    .HOLDUP_CYC(25'h05)) i_dut (.mclk(mclk), .rst(rst), .ce(ce), .flags(flg),
    .on_request_n(on_n), .cold_bus_in(cold_bus), .addr_select_bit0(a0),
    .addr_select_bit1(a1), .tele_wr(t_wr), .tele_idx(t_idx), .tele_data(t_data),
    .reg_req(req), .reg_rdata(rdata), .pgood_i(pg_i), .pgood_o(pg_o), .pgood_oe(pg_oe),
    .alert_n_i(al_i), .alert_n_o(al_o), .alert_n_oe(al_oe), .vin_good_i(vi_i),
    .vin_good_o(vi_o), .vin_good_oe(vi_oe), .unit_installed_n_i(in_i),
    .unit_installed_n_o(in_o), .unit_installed_n_oe(in_oe), .main_enable(main_en),
    .sleep_active(sleep), .led_red(led), .smbus_addr_lo(addr_lo));
  pss_board_model i_board (.pgood_o(pg_o), .pgood_oe(pg_oe), .alert_n_o(al_o),
    .alert_n_oe(al_oe), .vin_good_o(vi_o), .vin_good_oe(vi_oe), .inst_o(in_o),
    .inst_oe(in_oe), .cold_cmd(cold_cmd), .pgood_pin(pg_i), .alert_pin(al_i),
    .vin_pin(vi_i), .inst_pin(in_i), .cold_bus(cold_bus));
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Sample just after the edge so the flops have settled
  task automatic step(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Bounded wait for power good (0) or alert release (1)
  task automatic wait_lo(input int sel, input int bound);
    n = 0;
    // Look off the launching edge so the outputs have settled
    #1;
    while ((sel == 0 ? pg_oe : al_oe) !== 1'b0) begin
      n++;
      if (n > bound) begin
        mismatches++;
        $display("MISMATCH at %0t: got %h expected %h", $time, n, bound);
        close_out();
      end
      step(1);
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst, on_n, cold_cmd, a0, a1, t_wr, t_idx, t_data, req} = {1'b1, 9'h0, 16'h0, 26'h0};
    flg = '0;
    ce = 1'b1;
    flg.outputs_in_reg = 1'b1;
    flg.input_present = 1'b1;
    flg.input_in_range = 1'b1;
    mismatches = 0;
    n_checks = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rd(pss_pkg::REG_CTRL, rd_q);
    chk(rd_q, pss_pkg::CTRL_RESET);
    wait_lo(0, 80);
    chk(16'(n >= PL + PD - 3), 16'h1);
    @(posedge mclk);
    flg.outputs_in_reg <= 1'b0;
    step(1);
    chk(16'(pg_oe), 16'h1);
    @(posedge mclk);
    flg.outputs_in_reg <= 1'b1;
    flg.current_limit <= 1'b1;
    step(PL + PD + 10);
    chk(16'(pg_oe), 16'h1);
    @(posedge mclk);
    flg.current_limit <= 1'b0;
    wait_lo(0, PD + 5);
    chk(16'(n >= PD - 2), 16'h1);
    @(posedge mclk);
    on_n <= 1'b1;
    step(1);
    chk(16'(pg_oe), 16'h1);
    @(posedge mclk);
    on_n <= 1'b0;
    wait_lo(0, 80);
    chk(16'(n >= PL + PD - 1), 16'h1);
    for (int i = 2; i < 7; i++) begin
      @(posedge mclk);
      flg[i] <= 1'b1;
      @(posedge mclk);
      flg[i] <= 1'b0;
      #1 chk({14'h0, led, al_oe}, 16'h3);
      wait_lo(1, AH + 5);
      chk(16'(n >= AH - 2), 16'h1);
    end
    @(posedge mclk);
    flg.env_exceed <= 1'b1;
    step(3);
    chk(16'(al_oe), 16'h0);
    wr(pss_pkg::REG_CTRL, 16'h0010);
    step(1);
    chk(16'(al_oe), 16'h1);
    @(posedge mclk);
    flg.env_exceed <= 1'b0;
    wr(pss_pkg::REG_CTRL, 16'h0000);
    wait_lo(1, AH + 5);
    @(posedge mclk);
    flg.input_present <= 1'b0;
    step(10);
    chk({14'h0, vi_oe, pg_oe}, 16'h3);
    rd(pss_pkg::REG_STATUS, rd_q);
    chk(rd_q & 16'h2004, 16'h0000);
    @(posedge mclk);
    flg.input_present <= 1'b1;
    flg.input_in_range <= 1'b0;
    step(2);
    chk(16'(vi_oe), 16'h1);
    @(posedge mclk);
    flg.input_in_range <= 1'b1;
    step(2);
    chk(16'(vi_oe), 16'h0);
    for (int g = 0; g < 4; g++) begin
      wr(pss_pkg::REG_CTRL, 16'h0003 | 16'(g << 2));
      wr(pss_pkg::REG_STATUS, 16'hFFFF);
      rd(pss_pkg::REG_CTRL, rd_q);
      chk(rd_q, 16'h0003 | 16'(g << 2));
    end
    rd(8'h30, rd_q);
    chk(rd_q, 16'h0000);
    @(posedge mclk);
    cold_cmd <= 1'b1;
    step(2);
    chk({14'h0, sleep, main_en}, 16'h2);
    @(posedge mclk);
    cold_cmd <= 1'b0;
    step(2);
    chk({14'h0, sleep, main_en}, 16'h1);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      {a1, a0} <= 2'(i);
      step(2);
      chk(16'(addr_lo), 16'(i));
    end
    // Clock enable low must freeze the strap flops
    @(posedge mclk);
    ce <= 1'b0;
    {a1, a0} <= 2'h0;
    step(3);
    chk(16'(addr_lo), 16'h0003);
    @(posedge mclk);
    ce <= 1'b1;
    step(2);
    chk(16'(addr_lo), 16'h0000);
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      t_wr <= 1'b1;
      t_idx <= 4'(i);
      t_data <= 16'h1000 + 16'(i);
    end
    @(posedge mclk);
    t_wr <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rd(pss_pkg::REG_TELE_BASE + 8'(i), rd_q);
      chk(rd_q, 16'h1000 + 16'(i));
    end
    rd(8'h1A, rd_q);
    chk(rd_q, 16'h0000);
    close_out();
  end
endmodule
